/* File: rtl/amd_defines.svh */
`ifndef AMD_DEFINES_SVH
`define AMD_DEFINES_SVH
`define AMD_ADDR_W    16
`define AMD_PAGE0_TOP 16'h00FF
`define AMD_MASK_HIGH 2'h3
`define AMD_MASK_LOW  2'h0
`define AMD_MASK_RST  2'h3
`endif

/* File: rtl/amd_pkg.sv */
package amd_pkg;
    // Seventeen addressing modes in seven families.
    typedef enum logic [4:0] {
        AMD_INH      = 5'h00,
        AMD_IMM      = 5'h01,
        AMD_DIR_S    = 5'h02,
        AMD_DIR_L    = 5'h03,
        AMD_IDX_0    = 5'h04,
        AMD_IDX_S    = 5'h05,
        AMD_IDX_L    = 5'h06,
        AMD_IND_S    = 5'h07,
        AMD_IND_L    = 5'h08,
        AMD_INDX_S   = 5'h09,
        AMD_INDX_L   = 5'h0A,
        AMD_REL_D    = 5'h0B,
        AMD_REL_I    = 5'h0C,
        AMD_BIT_D    = 5'h0D,
        AMD_BIT_I    = 5'h0E,
        AMD_BIT_DR   = 5'h0F,
        AMD_BIT_IR   = 5'h10
    } amd_mode_e;

    typedef enum logic [2:0] {
        AMD_ST_IDLE = 3'b000,
        AMD_ST_EXT  = 3'b001,
        AMD_ST_PTR  = 3'b010,
        AMD_ST_PTRL = 3'b011,
        AMD_ST_DONE = 3'b100
    } amd_state_e;
endpackage

/* File: rtl/amd_decoder.sv */
`timescale 1ns/1ps
`include "amd_defines.svh"
// Summary of operation
// - Seventeen addressing modes in seven families are decoded.
// - Inherent instruction is one byte; no extension bytes fetched.
// - Immediate: opcode then one literal operand byte.
// - Short direct: one address byte, range 00 to FF.
// - Long direct: two address bytes, full 64 Kbyte space.
// - Indexed address is unsigned sum of X or Y and offset.
// - No-offset indexed fetches nothing; index alone addresses 00 to FF.
// - Short indexed: one offset byte, reach 00 to 1FE.
// - Long indexed: two offset bytes plus index, full space.
// - Indirect: byte after opcode is pointer address, pointer then read.
// - Short indirect byte pointer; long indirect word pointer; one byte.
// - Indirect indexed: index plus pointer value read from memory.
// - Short indirect indexed reaches 1FE; long reaches full space.
// - Short direct, indirect and bit forms reach page zero; short indexed forms up to 1FE; long forms whole space.
// - Read-modify-write instructions accept only short forms.
// - Mask raise sets level 3; mask lower sets level 0.
// - Relative adds 8-bit signed offset to program counter.
module amd_decoder (
    // Clock and reset.
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    // Instruction request.
    input  wire logic                      start,
    input  wire amd_pkg::amd_mode_e        mode,
    input  wire logic                      use_y,
    input  wire logic                      rmw,
    input  wire logic                      mask_raise_op,
    input  wire logic                      mask_lower_op,
    input  wire logic [7:0]                idx_x,
    input  wire logic [7:0]                idx_y,
    input  wire logic [15:0]               pc_next,
    // Memory byte port.
    output logic                           mem_rd,
    output logic [15:0]                    mem_addr,
    input  wire logic                      mem_ack,
    input  wire logic [7:0]                mem_data,
    // Results.
    output logic                           done,
    output logic                           illegal,
    output logic [15:0]                    ea,
    output logic [7:0]                     literal,
    output logic [15:0]                    branch_pc,
    output logic [1:0]                     irq_mask,
    output logic [1:0]                     ext_len
);
    amd_pkg::amd_state_e st_q, st_d;
    amd_pkg::amd_mode_e  md_q, md_d;
    logic [1:0]  cnt_q, cnt_d, need_q, need_d;
    logic [15:0] acc_q, acc_d, pc_q, pc_d, addr_q, addr_d, ea_q, ea_d;
    logic [7:0]  ix_q, ix_d, lit_q, lit_d;
    logic        rd_q, rd_d, dn_q, dn_d, il_q, il_d;
    logic [15:0] bpc_q, bpc_d;
    logic [1:0]  msk_q, msk_d, len_q, len_d;

    // Extension bytes that follow the opcode for each mode.
    function automatic logic [1:0] ext_bytes(amd_pkg::amd_mode_e m);
        case (m)
            amd_pkg::AMD_INH,
            amd_pkg::AMD_IDX_0: ext_bytes = 2'h0;
            amd_pkg::AMD_DIR_L, amd_pkg::AMD_IDX_L,
            amd_pkg::AMD_BIT_DR: ext_bytes = 2'h2;
            default: ext_bytes = 2'h1;
        endcase
    endfunction

    function automatic logic is_long(amd_pkg::amd_mode_e m);
        is_long = (m == amd_pkg::AMD_DIR_L) || (m == amd_pkg::AMD_IDX_L) ||
                  (m == amd_pkg::AMD_IND_L) || (m == amd_pkg::AMD_INDX_L);
    endfunction

    function automatic logic is_indirect(amd_pkg::amd_mode_e m);
        is_indirect = (m == amd_pkg::AMD_IND_S) ||
                      (m == amd_pkg::AMD_IND_L) ||
                      (m == amd_pkg::AMD_INDX_S) ||
                      (m == amd_pkg::AMD_INDX_L) ||
                      (m == amd_pkg::AMD_REL_I) ||
                      (m == amd_pkg::AMD_BIT_I) ||
                      (m == amd_pkg::AMD_BIT_IR);
    endfunction

    // Unsigned 8-bit index plus 16-bit base; short bases give at most 1FE.
    function automatic logic [15:0] idx_add(logic [15:0] b, logic [7:0] i);
        idx_add = b + {8'h00, i};
    endfunction

    function automatic logic [15:0] rel_add(logic [15:0] p, logic [7:0] o);
        rel_add = p + {{8{o[7]}}, o};
    endfunction

    // Final address for the mode once all bytes are in hand.
    function automatic logic [15:0] form_ea(amd_pkg::amd_mode_e m,
                                            logic [15:0] v, logic [7:0] i);
        case (m)
            amd_pkg::AMD_IDX_0: form_ea = {8'h00, i};
            amd_pkg::AMD_IDX_S, amd_pkg::AMD_IDX_L,
            amd_pkg::AMD_INDX_S, amd_pkg::AMD_INDX_L:
                form_ea = idx_add(v, i);
            // Bit direct-relative carries its branch offset in the low byte,
            // so only the first byte addresses the operand in page zero.
            amd_pkg::AMD_BIT_DR: form_ea = {8'h00, v[15:8]};
            default: form_ea = v;
        endcase
    endfunction

    always_comb begin
        st_d   = st_q;
        md_d   = md_q;
        cnt_d  = cnt_q;
        need_d = need_q;
        acc_d  = acc_q;
        pc_d   = pc_q;
        addr_d = addr_q;
        ix_d   = ix_q;
        lit_d  = lit_q;
        rd_d   = rd_q;
        dn_d   = 1'b0;
        il_d   = 1'b0;
        ea_d   = ea_q;
        bpc_d  = bpc_q;
        msk_d  = msk_q;
        len_d  = len_q;
        case (st_q)
            amd_pkg::AMD_ST_IDLE: begin
                if (start) begin
                    md_d  = mode;
                    ix_d  = use_y ? idx_y : idx_x;
                    pc_d  = pc_next;
                    acc_d = 16'h0000;
                    cnt_d = 2'h0;
                    len_d = ext_bytes(mode);
                    if (rmw && is_long(mode)) begin
                        il_d = 1'b1;
                        dn_d = 1'b1;
                    end else if (ext_bytes(mode) == 2'h0) begin
                        if (mask_raise_op) begin
                            msk_d = `AMD_MASK_HIGH;
                        end else if (mask_lower_op) begin
                            msk_d = `AMD_MASK_LOW;
                        end
                        ea_d = form_ea(mode, 16'h0000, use_y ? idx_y : idx_x);
                        dn_d = 1'b1;
                    end else begin
                        need_d = ext_bytes(mode);
                        addr_d = pc_next;
                        rd_d   = 1'b1;
                        st_d   = amd_pkg::AMD_ST_EXT;
                    end
                end
            end
            amd_pkg::AMD_ST_EXT: begin
                if (mem_ack) begin
                    acc_d  = {acc_q[7:0], mem_data};
                    cnt_d  = cnt_q + 2'h1;
                    addr_d = addr_q + 16'h0001;
                    if (cnt_q + 2'h1 == need_q) begin
                        rd_d = 1'b0;
                        st_d = amd_pkg::AMD_ST_DONE;
                        if (is_indirect(md_q)) begin
                            addr_d = {8'h00, mem_data};
                            rd_d   = 1'b1;
                            cnt_d  = 2'h0;
                            acc_d  = 16'h0000;
                            st_d   = amd_pkg::AMD_ST_PTR;
                        end
                    end
                end
            end
            amd_pkg::AMD_ST_PTR: begin
                if (mem_ack) begin
                    acc_d  = {acc_q[7:0], mem_data};
                    addr_d = addr_q + 16'h0001;
                    if (md_q == amd_pkg::AMD_IND_L ||
                        md_q == amd_pkg::AMD_INDX_L) begin
                        st_d = amd_pkg::AMD_ST_PTRL;
                    end else begin
                        rd_d = 1'b0;
                        st_d = amd_pkg::AMD_ST_DONE;
                    end
                end
            end
            amd_pkg::AMD_ST_PTRL: begin
                if (mem_ack) begin
                    acc_d = {acc_q[7:0], mem_data};
                    rd_d  = 1'b0;
                    st_d  = amd_pkg::AMD_ST_DONE;
                end
            end
            amd_pkg::AMD_ST_DONE: begin
                if (md_q == amd_pkg::AMD_IMM) begin
                    lit_d = acc_q[7:0];
                end
                if (md_q == amd_pkg::AMD_REL_D ||
                    md_q == amd_pkg::AMD_REL_I) begin
                    bpc_d = rel_add(pc_q + {14'h0000, len_q}, acc_q[7:0]);
                end
                ea_d = form_ea(md_q, acc_q, ix_q);
                dn_d = 1'b1;
                st_d = amd_pkg::AMD_ST_IDLE;
            end
            default: st_d = amd_pkg::AMD_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= amd_pkg::AMD_ST_IDLE;
            md_q   <= amd_pkg::AMD_INH;
            cnt_q  <= 2'h0;
            need_q <= 2'h0;
            acc_q  <= 16'h0000;
            pc_q   <= 16'h0000;
            addr_q <= 16'h0000;
            ix_q   <= 8'h00;
            lit_q  <= 8'h00;
            rd_q   <= 1'b0;
            dn_q   <= 1'b0;
            il_q   <= 1'b0;
            ea_q   <= 16'h0000;
            bpc_q  <= 16'h0000;
            msk_q  <= `AMD_MASK_RST;
            len_q  <= 2'h0;
        end else begin
            st_q   <= st_d;
            md_q   <= md_d;
            cnt_q  <= cnt_d;
            need_q <= need_d;
            acc_q  <= acc_d;
            pc_q   <= pc_d;
            addr_q <= addr_d;
            ix_q   <= ix_d;
            lit_q  <= lit_d;
            rd_q   <= rd_d;
            dn_q   <= dn_d;
            il_q   <= il_d;
            ea_q   <= ea_d;
            bpc_q  <= bpc_d;
            msk_q  <= msk_d;
            len_q  <= len_d;
        end
    end

    assign mem_rd    = rd_q;
    assign mem_addr  = addr_q;
    assign done      = dn_q;
    assign illegal   = il_q;
    assign ea        = ea_q;
    assign literal   = lit_q;
    assign branch_pc = bpc_q;
    assign irq_mask  = msk_q;
    assign ext_len   = len_q;

    // Checks below watch registered state plus the request and memory port inputs sampled at the clock edge.
    a_short_page0: assert property (
        @(posedge clock) disable iff (!rst_b)
        (dn_q && !il_q && md_q == amd_pkg::AMD_DIR_S) |-> ea_q[15:8] == 8'h00)
        else $error("short direct address left page zero");
    a_idx_short_top: assert property (
        @(posedge clock) disable iff (!rst_b)
        (dn_q && (md_q == amd_pkg::AMD_IDX_S || md_q == amd_pkg::AMD_INDX_S))
        |-> ea_q <= 16'h01FE)
        else $error("short indexed address above 1FE");
    a_mask_raise: assert property (
        @(posedge clock) disable iff (!rst_b)
        (st_q == amd_pkg::AMD_ST_IDLE && start && mask_raise_op && !rmw &&
         mode == amd_pkg::AMD_INH) |=> msk_q == 2'h3)
        else $error("mask raise did not reach level 3");
    a_mask_lower: assert property (
        @(posedge clock) disable iff (!rst_b)
        (st_q == amd_pkg::AMD_ST_IDLE && start && mask_lower_op &&
         !mask_raise_op && mode == amd_pkg::AMD_INH) |=> msk_q == 2'h0)
        else $error("mask lower did not reach level 0");
    a_inh_noread: assert property (
        @(posedge clock) disable iff (!rst_b)
        (st_q == amd_pkg::AMD_ST_IDLE && start && mode == amd_pkg::AMD_INH)
        |=> !rd_q && dn_q)
        else $error("inherent instruction fetched a byte");
    a_rmw_long: assert property (
        @(posedge clock) disable iff (!rst_b)
        (st_q == amd_pkg::AMD_ST_IDLE && start && rmw &&
         mode == amd_pkg::AMD_DIR_L) |=> il_q && !rd_q)
        else $error("long form accepted for read-modify-write");
    a_ptr_page0: assert property (
        @(posedge clock) disable iff (!rst_b)
        (st_q == amd_pkg::AMD_ST_PTR) |-> addr_q[15:8] == 8'h00)
        else $error("pointer address outside page zero");
    a_idx0_ea: assert property (
        @(posedge clock) disable iff (!rst_b)
        (st_q == amd_pkg::AMD_ST_IDLE && start && !rmw &&
         mode == amd_pkg::AMD_IDX_0 && !use_y)
        |=> ea_q == {8'h00, $past(idx_x)})
        else $error("no-offset indexed address wrong");

    // The pointer walk has two steps: take its address, then read the word.
    sequence s_ptr_addr_taken;
        st_q == amd_pkg::AMD_ST_EXT && mem_ack && is_indirect(md_q) &&
        cnt_q + 2'h1 == need_q;
    endsequence
    sequence s_ptr_high_taken;
        st_q == amd_pkg::AMD_ST_PTR && mem_ack &&
        (md_q == amd_pkg::AMD_IND_L || md_q == amd_pkg::AMD_INDX_L);
    endsequence
    a_ptr_from_ext: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_ptr_addr_taken |=> st_q == amd_pkg::AMD_ST_PTR && rd_q &&
        addr_q == {8'h00, $past(mem_data)})
        else $error("pointer address not taken from byte");
    a_ptr_word_order: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_ptr_high_taken |=> st_q == amd_pkg::AMD_ST_PTRL && rd_q &&
        addr_q == $past(addr_q) + 16'h0001)
        else $error("low pointer byte not read next");
    a_bit_page0: assert property (
        @(posedge clock) disable iff (!rst_b)
        (dn_q && !il_q && (md_q == amd_pkg::AMD_BIT_D ||
         md_q == amd_pkg::AMD_BIT_I || md_q == amd_pkg::AMD_BIT_DR ||
         md_q == amd_pkg::AMD_BIT_IR)) |-> ea_q[15:8] == 8'h00)
        else $error("bit operand address left page zero");
endmodule

/* File: tb/amd_mem_model.sv */
`timescale 1ns/1ps
module amd_mem_model (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Byte read port.
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    output logic             mem_ack,
    output logic [7:0]       mem_data,
    // Response pacing.
    input  wire logic        slow
);
    logic [1:0] wait_q;

    // Memory contents follow the address so expectations need no table.
    function automatic logic [7:0] byte_at(input logic [15:0] a);
        return a[7:0] + a[15:8] + 8'h3C;
    endfunction

    // A gap cycle after each ack keeps one address from being served twice.
    // Data toggles outside acks so a late sample never sees a stale byte.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mem_ack <= 1'b0;
            mem_data <= 8'h00;
            wait_q <= 2'h0;
        end else if (mem_rd && !mem_ack && (!slow || wait_q == 2'h3)) begin
            mem_ack <= 1'b1;
            mem_data <= byte_at(mem_addr);
            wait_q <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_data <= ~mem_data;
            if (mem_rd && !mem_ack) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clock, rst_b, start, use_y, rmw, slow, ill;
    logic mask_raise_op, mask_lower_op, mem_rd, mem_ack, done, illegal;
    logic [7:0] idx_x, idx_y, mem_data, literal;
    logic [15:0] pc_next, mem_addr, ea, branch_pc;
    logic [1:0] irq_mask, ext_len;
    amd_pkg::amd_mode_e mode;
    int miscompares, cmp_count, acks;
    logic [7:0] b0, b1, p0, p1;

    amd_decoder i_amd_decoder (.clock(clock), .rst_b(rst_b), .start(start),
        .mode(mode), .use_y(use_y), .rmw(rmw), .mask_raise_op(mask_raise_op),
        .mask_lower_op(mask_lower_op), .idx_x(idx_x), .idx_y(idx_y),
        .pc_next(pc_next), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_data(mem_data), .done(done),
        .illegal(illegal), .ea(ea), .literal(literal),
        .branch_pc(branch_pc), .irq_mask(irq_mask), .ext_len(ext_len));
    amd_mem_model i_amd_mem_model (.clock(clock), .rst_b(rst_b),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_data(mem_data), .slow(slow));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        if (mem_ack === 1'b1) acks++;
    end

    task automatic close_out();
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Issues one request and returns at the cycle in which done is high.
    task automatic op(input amd_pkg::amd_mode_e m, input logic y, r, rs, lw);
        int n;
        @(posedge clock);
        #1;
        mode = m;
        use_y = y;
        rmw = r;
        mask_raise_op = rs;
        mask_lower_op = lw;
        start = 1'b1;
        acks = 0;
        @(posedge clock);
        #1;
        start = 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (done !== 1'b1 && n < 200);
        ill = illegal;
        chk("done seen", 16'h0001, {15'h0000, done});
    endtask

    task automatic t_reset();
        chk("irq_mask at reset", 16'h0003, {14'h0000, irq_mask});
        chk("mem_rd at reset", 16'h0000, {15'h0000, mem_rd});
    endtask

    task automatic t_inherent();
        op(amd_pkg::AMD_INH, 1'b0, 1'b0, 1'b0, 1'b1);
        chk("mask lowered", 16'h0000, {14'h0000, irq_mask});
        chk("inherent acks", 16'h0000, acks[15:0]);
        chk("inherent len", 16'h0000, {14'h0000, ext_len});
        op(amd_pkg::AMD_INH, 1'b0, 1'b0, 1'b1, 1'b1);
        chk("mask raised", 16'h0003, {14'h0000, irq_mask});
    endtask

    task automatic t_immediate();
        op(amd_pkg::AMD_IMM, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("literal", {8'h00, b0}, {8'h00, literal});
        chk("imm len", 16'h0001, {14'h0000, ext_len});
    endtask

    task automatic t_direct();
        op(amd_pkg::AMD_DIR_S, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("short direct ea", {8'h00, b0}, ea);
        chk("short direct acks", 16'h0001, acks[15:0]);
        op(amd_pkg::AMD_BIT_DR, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("bit dr ea", {8'h00, b0}, ea);
        chk("bit dr acks", 16'h0002, acks[15:0]);
        @(posedge clock);
        #1;
        slow = 1'b1;
        op(amd_pkg::AMD_DIR_L, 1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge clock);
        #1;
        slow = 1'b0;
        chk("long direct ea", {b0, b1}, ea);
        chk("long direct len", 16'h0002, {14'h0000, ext_len});
    endtask

    task automatic t_indexed();
        op(amd_pkg::AMD_IDX_0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("no offset ea", {8'h00, idx_x}, ea);
        chk("no offset acks", 16'h0000, acks[15:0]);
        op(amd_pkg::AMD_IDX_S, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("short ix x", {8'h00, b0} + {8'h00, idx_x}, ea);
        op(amd_pkg::AMD_IDX_S, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("short idx y", {8'h00, b0} + {8'h00, idx_y}, ea);
        op(amd_pkg::AMD_IDX_L, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("long idx", {b0, b1} + {8'h00, idx_x}, ea);
    endtask

    task automatic t_indirect();
        op(amd_pkg::AMD_IND_S, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("short ind ea", {8'h00, p0}, ea);
        chk("short ind acks", 16'h0002, acks[15:0]);
        op(amd_pkg::AMD_IND_L, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("long ind ea", {p0, p1}, ea);
        chk("long ind acks", 16'h0003, acks[15:0]);
        op(amd_pkg::AMD_INDX_S, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("s indx", {8'h00, p0} + {8'h00, idx_x}, ea);
        op(amd_pkg::AMD_INDX_L, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("long indx", {p0, p1} + {8'h00, idx_y}, ea);
    endtask

    task automatic t_relative();
        logic [15:0] bt;
        bt = pc_next + 16'h0001 + {{8{b0[7]}}, b0};
        op(amd_pkg::AMD_REL_D, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("branch", bt, branch_pc);
    endtask

    // Every long form is refused for read-modify-write; a short one is not.
    task automatic t_rmw();
        amd_pkg::amd_mode_e lm[4];
        lm = '{amd_pkg::AMD_DIR_L, amd_pkg::AMD_IDX_L,
               amd_pkg::AMD_IND_L, amd_pkg::AMD_INDX_L};
        foreach (lm[i]) begin
            op(lm[i], 1'b0, 1'b1, 1'b0, 1'b0);
            chk("rmw long refused", 16'h0001, {15'h0000, ill});
        end
        op(amd_pkg::AMD_DIR_S, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("rmw short accepted", 16'h0000, {15'h0000, ill});
    endtask

    task automatic t_all_modes();
        for (int i = 0; i < 17; i++) begin
            op(amd_pkg::amd_mode_e'(i), 1'b0, 1'b0, 1'b0, 1'b0);
            chk("mode accepted", 16'h0000, {15'h0000, ill});
        end
    endtask

    initial begin
        miscompares = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        start = 1'b0;
        use_y = 1'b0;
        rmw = 1'b0;
        slow = 1'b0;
        mask_raise_op = 1'b0;
        mask_lower_op = 1'b0;
        mode = amd_pkg::AMD_INH;
        idx_x = 8'hF0;
        idx_y = 8'h07;
        pc_next = 16'h1234;
        b0 = i_amd_mem_model.byte_at(16'h1234);
        b1 = i_amd_mem_model.byte_at(16'h1235);
        p0 = i_amd_mem_model.byte_at({8'h00, b0});
        p1 = i_amd_mem_model.byte_at({8'h00, b0 + 8'h01});
        repeat (6) @(posedge clock);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_inherent();
        t_immediate();
        t_direct();
        t_indexed();
        t_indirect();
        t_relative();
        t_rmw();
        t_all_modes();
        close_out();
    end

    // About 40 requests of at most about a dozen cycles each fit well inside this.
    initial begin
        repeat (8000) @(posedge clock);
        miscompares++;
        close_out();
    end
endmodule
